// >>> logic/aie_core.v
`timescale 1ns/1ps
`include "aie_regs.vh"

// Contract
// - Decode add-accumulator-to-file opcode and add accumulator to addressed file byte.
// - Destination bit 0 writes sum to accumulator; 1 writes back to file.
// - Addressing bit 0 resolves file operands up to 95 within access page 0 (extended set clear) and higher operands within access page 15.
// - Addressing bit 1 forms address from bank select register and file operand.
// - Addressing bit 0 with extended set: operands up to 95 are indexed offsets.
// - Decode add-immediate, add literal to accumulator, store there, update all flags.
module aie_core (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire        wb_ack_o,
    output wire [11:0] memAddr,
    input  wire [7:0]  memRdData,
    output wire [7:0]  memWrData,
    output wire        memWe
);
    // ****************************************
    // Phase states
    // ****************************************
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_DEC  = 5'h02;
    localparam [4:0] ST_READ = 5'h04;
    localparam [4:0] ST_PROC = 5'h08;
    localparam [4:0] ST_WRIT = 5'h10;

    function isAddImm;
        input [15:0] w;
        begin
            isAddImm = (w[15:8] == `AIE_OPC_IMM);
        end
    endfunction

    function isAddFile;
        input [15:0] w;
        begin
            isAddFile = (w[15:10] == `AIE_OPC_FILE);
        end
    endfunction

    // ****************************************
    // Reset synchroniser
    // ****************************************
    reg rstMeta_reg;
    reg rstSync_reg;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rstMeta_reg <= 1'b0;
            rstSync_reg <= 1'b0;
        end else begin
            rstMeta_reg <= 1'b1;
            rstSync_reg <= rstMeta_reg;
        end
    end
    wire rstN = rstSync_reg;

    reg  [4:0]  state_reg;
    reg  [15:0] instr_reg;
    reg  [7:0]  acc_reg;
    reg  [3:0]  bank_reg;
    reg  [4:0]  flags_reg;
    reg  [11:0] index_reg;
    reg         extEn_reg;
    reg         illegal_reg;
    reg  [7:0]  opB_reg;
    reg  [7:0]  result_reg;
    reg  [4:0]  resFlags_reg;
    reg  [11:0] memAddr_reg;
    reg         memWe_reg;
    reg         ack_reg;
    reg  [31:0] rdData_reg;

    wire [7:0]  sum;
    wire [4:0]  sumFlags;
    wire        busy    = (state_reg != ST_IDLE);
    wire        wbReq   = wb_cyc_i && wb_stb_i && !ack_reg;
    wire        wbWr    = wbReq && wb_we_i && wb_sel_i[0];
    wire        instrWr = wbWr && (wb_adr_i == `AIE_OFS_INSTR) && !busy;
    wire        fileOp  = isAddFile(instr_reg);
    wire        destFile  = instr_reg[`AIE_INSTR_DEST_BIT];
    wire        useBank   = instr_reg[`AIE_INSTR_ACC_BIT];
    wire [7:0]  fOperand  = instr_reg[7:0];

    aie_adder uAdder (
        .opA   (acc_reg),
        .opB   (opB_reg),
        .sum   (sum),
        .flags (sumFlags)
    );

    // ****************************************
    // Operand address resolution
    // ****************************************
    reg [11:0] fileAddr;
    always @* begin
        if (useBank) begin
            fileAddr = {bank_reg, fOperand};
        end else if (extEn_reg && fOperand <= `AIE_INDEX_LIMIT) begin
            fileAddr = index_reg + {4'h0, fOperand};
        end else if (fOperand <= `AIE_INDEX_LIMIT) begin
            fileAddr = {`AIE_ACCESS_LOW, fOperand};
        end else begin
            fileAddr = {`AIE_ACCESS_HIGH, fOperand};
        end
    end

    // ****************************************
    // Four-phase execution
    // ****************************************
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            state_reg    <= ST_IDLE;
            instr_reg    <= `AIE_RST_INSTR;
            acc_reg      <= `AIE_RST_ACC;
            flags_reg    <= `AIE_RST_FLAGS;
            illegal_reg  <= 1'b0;
            opB_reg      <= 8'h00;
            result_reg   <= 8'h00;
            resFlags_reg <= 5'h00;
            memAddr_reg  <= 12'h000;
            memWe_reg    <= 1'b0;
        end else begin
            case (state_reg)
                ST_IDLE: begin
                    memWe_reg <= 1'b0;
                    if (instrWr) begin
                        instr_reg <= wb_dat_i[15:0];
                        state_reg <= ST_DEC;
                    end else begin
                        if (wbWr && wb_adr_i == `AIE_OFS_ACC) begin
                            acc_reg <= wb_dat_i[7:0];
                        end
                        if (wbWr && wb_adr_i == `AIE_OFS_STATUS) begin
                            flags_reg <= wb_dat_i[4:0];
                        end
                    end
                end
                ST_DEC: begin
                    // Unknown codes end here with no effect except the flag
                    if (isAddImm(instr_reg) || fileOp) begin
                        illegal_reg <= 1'b0;
                        memAddr_reg <= fileAddr;
                        state_reg   <= ST_READ;
                    end else begin
                        illegal_reg <= 1'b1;
                        state_reg   <= ST_IDLE;
                    end
                end
                ST_READ: begin
                    opB_reg   <= fileOp ? memRdData : instr_reg[7:0];
                    state_reg <= ST_PROC;
                end
                ST_PROC: begin
                    result_reg   <= sum;
                    resFlags_reg <= sumFlags;
                    memWe_reg    <= fileOp && destFile;
                    state_reg    <= ST_WRIT;
                end
                ST_WRIT: begin
                    memWe_reg <= 1'b0;
                    flags_reg <= resFlags_reg;
                    if (!(fileOp && destFile)) begin
                        acc_reg <= result_reg;
                    end
                    state_reg <= ST_IDLE;
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    // Writes while busy are dropped so a running instruction sees a steady bank and base
    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            extEn_reg <= `AIE_RST_CTRL;
            bank_reg  <= `AIE_RST_BANK;
            index_reg <= `AIE_RST_INDEX;
        end else if (wbWr && !busy) begin
            if (wb_adr_i == `AIE_OFS_CTRL) begin
                extEn_reg <= wb_dat_i[`AIE_CTRL_EXT_BIT];
            end
            if (wb_adr_i == `AIE_OFS_BANK) begin
                bank_reg <= wb_dat_i[3:0];
            end
            if (wb_adr_i == `AIE_OFS_INDEX && wb_sel_i[1]) begin
                index_reg <= wb_dat_i[11:0];
            end
        end
    end

    // ****************************************
    // Wishbone read path and acknowledge
    // ****************************************
    reg [31:0] rdMux;
    always @* begin
        case (wb_adr_i)
            `AIE_OFS_CTRL:   rdMux = {31'h0, extEn_reg};
            `AIE_OFS_INSTR:  rdMux = {16'h0, instr_reg};
            `AIE_OFS_ACC:    rdMux = {24'h0, acc_reg};
            `AIE_OFS_BANK:   rdMux = {28'h0, bank_reg};
            `AIE_OFS_STATUS: rdMux = {22'h0, illegal_reg, busy, 3'h0, flags_reg};
            `AIE_OFS_INDEX:  rdMux = {20'h0, index_reg};
            default:         rdMux = 32'h0000_0000;
        endcase
    end

    always @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            ack_reg    <= 1'b0;
            rdData_reg <= 32'h0000_0000;
        end else begin
            ack_reg    <= wbReq;
            rdData_reg <= wbReq ? rdMux : rdData_reg;
        end
    end

    assign wb_ack_o  = ack_reg;
    assign wb_dat_o  = rdData_reg;
    assign memAddr   = memAddr_reg;
    assign memWrData = result_reg;
    assign memWe     = memWe_reg;
endmodule // aie_core

// >>> include/aie_regs.vh
`ifndef AIE_REGS_VH
`define AIE_REGS_VH

// ****************************************
// Register byte offsets
// ****************************************
`define AIE_OFS_CTRL        8'h00
`define AIE_OFS_INSTR       8'h04
`define AIE_OFS_ACC         8'h08
`define AIE_OFS_BANK        8'h0C
`define AIE_OFS_STATUS      8'h10
`define AIE_OFS_INDEX       8'h14

// ****************************************
// Field positions
// ****************************************
`define AIE_CTRL_EXT_BIT    0
`define AIE_ST_CARRY_BIT    0
`define AIE_ST_HALF_BIT     1
`define AIE_ST_ZERO_BIT     2
`define AIE_ST_WRAP_BIT     3
`define AIE_ST_NEG_BIT      4
`define AIE_ST_BUSY_BIT     8
`define AIE_ST_ILLEGAL_BIT  9
`define AIE_INSTR_DEST_BIT  9
`define AIE_INSTR_ACC_BIT   8

// ****************************************
// Opcode fields and address constants
// ****************************************
`define AIE_OPC_IMM         8'h0F
`define AIE_OPC_FILE        6'h09
`define AIE_INDEX_LIMIT     8'h5F
`define AIE_ACCESS_HIGH     4'hF
`define AIE_ACCESS_LOW      4'h0

// ****************************************
// Reset values
// ****************************************
`define AIE_RST_CTRL        1'h0
`define AIE_RST_INSTR       16'h0000
`define AIE_RST_ACC         8'h00
`define AIE_RST_BANK        4'h0
`define AIE_RST_FLAGS       5'h00
`define AIE_RST_INDEX       12'h000

`endif

// >>> logic/aie_adder.v
`timescale 1ns/1ps

// ****************************************
// 8-bit adder with status flags
// ****************************************
module aie_adder (
    input  wire [7:0] opA,
    input  wire [7:0] opB,
    output wire [7:0] sum,
    output wire [4:0] flags
);
    wire [8:0] full;
    wire [4:0] low;

    assign full = {1'b0, opA} + {1'b0, opB};
    assign low  = {1'b0, opA[3:0]} + {1'b0, opB[3:0]};
    assign sum  = full[7:0];

    // Flags packed as {neg, wrap, zero, half, carry}
    assign flags[0] = full[8];
    assign flags[1] = low[4];
    assign flags[2] = (full[7:0] == 8'h00);
    // Signed wrap: both inputs share a sign the result lacks
    assign flags[3] = (opA[7] == opB[7]) && (full[7] != opA[7]);
    assign flags[4] = full[7];
endmodule // aie_adder

// >>> sim/aie_core_props.sv
`timescale 1ns/1ps
`include "aie_regs.vh"
module aie_core_props (
    input logic        clk,
    input logic        rst_n,
    input logic        wb_cyc_i,
    input logic        wb_stb_i,
    input logic        wb_we_i,
    input logic [7:0]  wb_adr_i,
    input logic [31:0] wb_dat_i,
    input logic        wb_ack_o,
    input logic [11:0] memAddr,
    input logic        memWe
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire ins = req && wb_we_i && wb_adr_i == `AIE_OFS_INSTR;
    wire fil = ins && wb_dat_i[15:10] == `AIE_OPC_FILE;
    sequence noWrite;
        !memWe [*4];
    endsequence
    sequence fileWrite;
        ##1 !memWe [*3] ##1 memWe;
    endsequence
    chk_ack_next: assert property (req |=> wb_ack_o) else $error("ack missing");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    chk_we_pulse: assert property (memWe |=> !memWe) else $error("write strobe too long");
    chk_file_write: assert property (fil && wb_dat_i[9] |-> fileWrite)
        else $error("file write misplaced");
    chk_acc_dest: assert property (fil && !wb_dat_i[9] |=> noWrite) else $error("stray write");
    chk_imm_dest: assert property (ins && wb_dat_i[15:8] == `AIE_OPC_IMM |=> noWrite)
        else $error("immediate wrote memory");
    chk_page_addr: assert property (fil && !wb_dat_i[8] && wb_dat_i[7:0] > `AIE_INDEX_LIMIT
        |-> ##2 memAddr == {`AIE_ACCESS_HIGH, $past(wb_dat_i[7:0], 2)}) else $error("bad page address");
    chk_addr_held: assert property (memWe |-> memAddr == $past(memAddr, 2)) else $error("address moved");
endmodule // aie_core_props
bind aie_core aie_core_props u_props (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
    .memAddr(memAddr), .memWe(memWe));

// >>> sim/aie_mem_model.sv
`timescale 1ns/1ps
// ****
// Data memory, read path is combinational
// ****
module aie_mem_model (
    input logic        clk,
    input logic [11:0] addr,
    output logic [7:0] rdData,
    input logic [7:0]  wrData,
    input logic        we
);
    logic [7:0] cells [0:4095];
    assign rdData = cells[addr];
    always @(posedge clk) begin
        if (we) begin
            cells[addr] <= wrData;
        end
    end
endmodule // aie_mem_model

// >>> sim/aie_core_test.sv
`timescale 1ns/1ps
`include "aie_regs.vh"
module aie_core_test;
    logic        clk = 0, rst_n = 0, cyc = 0, we = 0, ack, memWe;
    logic [7:0]  adr = 0, memRd, memWr;
    logic [31:0] datI = 0, datO, rd;
    logic [11:0] memAddr;
    integer      failures = 0, nChecks = 0, i;
    always #5 clk = ~clk;
    aie_core DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(4'hF), .wb_dat_i(datI), .wb_dat_o(datO), .wb_ack_o(ack), .memAddr(memAddr),
        .memRdData(memRd), .memWrData(memWr), .memWe(memWe));
    aie_mem_model mem (.clk(clk), .addr(memAddr), .rdData(memRd), .wrData(memWr), .we(memWe));
    // ****
    // Bus access and checking
    // ****
    task check(input string name, input [31:0] exp, input [31:0] got);
        nChecks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask
    // Waits for ack with no limit of its own; the watchdog ends a hang
    task bus(input w, input [7:0] a, input [31:0] d);
        cyc <= 1;
        we <= w;
        adr <= a;
        datI <= d;
        @(posedge clk);
        while (ack !== 1'b1) begin
            @(posedge clk);
        end
        rd = datO;
        cyc <= 0;
        @(posedge clk);
    endtask
    // Busy is polled so that no instruction lands on a running one
    task waitIdle;
        rd = 32'h100;
        while (rd[`AIE_ST_BUSY_BIT] !== 1'b0) begin
            bus(0, `AIE_OFS_STATUS, 0);
        end
    endtask
    task exec(input [15:0] ins);
        bus(1, `AIE_OFS_INSTR, {16'h0, ins});
        waitIdle;
    endtask
    function [7:0] pat(input [11:0] x);
        pat = x[7:0] ^ {x[11:8], x[11:8]};
    endfunction
    function [4:0] flg(input [7:0] x, y);
        logic [8:0] s;
        s = x + y;
        flg = {s[7], x[7] == y[7] && s[7] != x[7], s[7:0] == 0, x[3:0] + y[3:0] > 15, s[8]};
    endfunction
    task immCase(input [7:0] acc, k);
        bus(1, `AIE_OFS_ACC, acc);
        exec({`AIE_OPC_IMM, k});
        bus(0, `AIE_OFS_ACC, 0);
        check("acc", 8'(acc + k), rd);
        bus(0, `AIE_OFS_STATUS, 0);
        check("flags", flg(acc, k), rd);
    endtask
    task fileCase(input a, d, e, input [7:0] f, input [3:0] bk, input [11:0] ix, input [7:0] acc, input [11:0] ea);
        logic [7:0] s;
        s = acc + pat(ea);
        bus(1, `AIE_OFS_CTRL, e);
        bus(1, `AIE_OFS_BANK, bk);
        bus(1, `AIE_OFS_INDEX, ix);
        bus(1, `AIE_OFS_ACC, acc);
        exec({`AIE_OPC_FILE, d, a, f});
        bus(0, `AIE_OFS_ACC, 0);
        check("acc", d ? acc[7:0] : s, rd);
        bus(0, `AIE_OFS_STATUS, 0);
        check("flags", flg(acc, pat(ea)), rd);
        check("memory", d ? s : pat(ea), mem.cells[ea]);
        mem.cells[ea] = pat(ea);
    endtask
    task testDone;
        $display("checks %0d, failures %0d", nChecks, failures);
        if (failures == 0 && nChecks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    initial begin
        #100000;
        failures++;
        testDone;
    end
    initial begin
        for (i = 0; i < 4096; i++) mem.cells[i] = pat(i);
        repeat (10) @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        bus(0, `AIE_OFS_ACC, 0);
        check("acc reset", `AIE_RST_ACC, rd);
        bus(1, 8'h40, 32'hFF);
        bus(0, 8'h40, 0);
        check("unmapped", 0, rd);
        bus(1, `AIE_OFS_BANK, 32'hFF);
        bus(0, `AIE_OFS_BANK, 0);
        check("bank", 32'hF, rd);
        bus(1, `AIE_OFS_STATUS, 32'h1F);
        bus(0, `AIE_OFS_STATUS, 0);
        check("status write", 32'h1F, rd);
        immCase(8'h10, 8'h15);
        immCase(8'h88, 8'h88);
        immCase(8'h7F, 8'h01);
        immCase(8'hFF, 8'h01);
        // Bank write lands while the instruction runs and must be dropped
        bus(1, `AIE_OFS_ACC, 32'h20);
        bus(1, `AIE_OFS_INSTR, {16'h0, `AIE_OPC_IMM, 8'h03});
        bus(1, `AIE_OFS_BANK, 32'h9);
        waitIdle;
        bus(0, `AIE_OFS_BANK, 0);
        check("bank while busy", 32'hF, rd);
        bus(0, `AIE_OFS_ACC, 0);
        check("acc", 32'h23, rd);
        fileCase(1, 0, 0, 8'hC2, 4'h3, 12'h0, 8'h17, 12'h3C2);
        fileCase(1, 1, 1, 8'h10, 4'hA, 12'h0, 8'h44, 12'hA10);
        fileCase(0, 0, 0, 8'h5F, 4'hA, 12'h800, 8'h01, 12'h05F);
        fileCase(0, 1, 0, 8'h60, 4'h5, 12'h0, 8'hF0, 12'hF60);
        fileCase(0, 1, 1, 8'h5F, 4'h5, 12'hFF0, 8'h80, 12'h04F);
        fileCase(0, 0, 1, 8'h60, 4'h5, 12'hFF0, 8'h7F, 12'hF60);
        // Second reset in mid-run must clear a non-zero accumulator
        rst_n <= 0;
        repeat (2) @(posedge clk);
        rst_n <= 1;
        repeat (3) @(posedge clk);
        bus(0, `AIE_OFS_ACC, 0);
        check("acc after reset", `AIE_RST_ACC, rd);
        exec(16'h0000);
        check("illegal", 32'h200, rd & 32'h200);
        testDone;
    end
endmodule // aie_core_test
